/* rtl/psram_defs.svh */
// Purpose: constants of the octal DDR pseudo-static memory transaction block
// Assumes: included by bare name; system clock of 125 MHz
// Notes:   config fields and register selects are local encodings
`ifndef PSRAM_DEFS_SVH
`define PSRAM_DEFS_SVH

`define ARRAY_ADDR_W 22
`define ROW_W 9

`define CR0_LAT_MSB 7
`define CR0_LAT_LSB 4
`define CR0_HYB_BIT 2
`define CR0_BL_MSB 1
`define CR0_BL_LSB 0
`define CR0_RESET 16'h8060
`define CR1_RESET 16'h0002

`define REG_SEL_ID0 2'h0
`define REG_SEL_ID1 2'h1
`define REG_SEL_CR0 2'h2
`define REG_SEL_CR1 2'h3

`define CLK_SYS_MHZ 125
`define REFRESH_INTERVAL_NS 4000
`define REFRESH_BUSY_NS 40
`define REFRESH_INTERVAL_CYC ((`REFRESH_INTERVAL_NS * `CLK_SYS_MHZ) / 1000)
`define REFRESH_BUSY_CYC (((`REFRESH_BUSY_NS * `CLK_SYS_MHZ) + 999) / 1000)

`endif

/* rtl/psram_pkg.sv */
// Purpose: types shared by the transaction block and its array
// Assumes: nothing
// Notes:   command word field order follows bit 47 down to bit 0
package psram_pkg;

  typedef struct packed {
    logic        is_read;
    logic        is_reg;
    logic        linear;
    logic [28:0] row_col;
    logic [12:0] unused;
    logic [2:0]  col_low;
  } ca_cmd_t;

  typedef enum logic [2:0] {
    ST_CA     = 3'b000,
    ST_LAT    = 3'b001,
    ST_RD     = 3'b010,
    ST_WR     = 3'b011,
    ST_REG_WR = 3'b100,
    ST_DONE   = 3'b101
  } link_state_t;

  typedef struct packed {
    logic        we;
    logic [1:0]  be;
    logic [15:0] data;
  } mem_wr_t;

endpackage

/* rtl/sync2.sv */
// Purpose: two-flop level synchroniser
// Assumes: d_i is a level that is stable for several destination clocks
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_reg;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= RESET_VAL;
      q_o      <= RESET_VAL;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule

`default_nettype wire

/* rtl/word_memory.sv */
// Purpose: word-wide array with byte enables and registered read data
// Assumes: one clock, read and write share the address
// Notes:   a read of the word being written returns its old contents
`timescale 1ns/1ps
`default_nettype none
`include "psram_defs.svh"

module word_memory #(
  parameter int ADDR_W = `ARRAY_ADDR_W
) (
  input  wire logic               clk_i,
  input  wire logic [ADDR_W-1:0]  addr_i,
  input  wire psram_pkg::mem_wr_t wr_i,
  output logic      [15:0]        rdata_o
);

  logic [15:0] mem [0:(2**ADDR_W)-1];

  always_ff @(posedge clk_i) begin
    if (wr_i.we && wr_i.be[1]) begin
      mem[addr_i][15:8] <= wr_i.data[15:8];
    end
    if (wr_i.we && wr_i.be[0]) begin
      mem[addr_i][7:0] <= wr_i.data[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem[addr_i];
  end

endmodule

`default_nettype wire

/* rtl/ddr_octal_psram_transactions.sv */
// Purpose: device-side transactions of an octal DDR pseudo-static memory:
//          command decode, latency, read and write bursts, registers
// Assumes: link clock idles low between frames; chip select falls at
//          least three system clocks before the first rising link edge
// Notes:   ADDR_W sizes the array; shrink it for simulation
`timescale 1ns/1ps
`default_nettype none
`include "psram_defs.svh"

module ddr_octal_psram_transactions #(
  parameter int          ADDR_W    = `ARRAY_ADDR_W,
  // Identification words: values are arbitrary
  parameter logic [15:0] ID0_VALUE = 16'h0C81,
  parameter logic [15:0] ID1_VALUE = 16'h000A
) (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       link_clk_i,
  input  wire logic       chip_select_n_i,
  input  wire logic [7:0] dq_i,
  output logic      [7:0] dq_o,
  output logic            dq_oe_o,
  input  wire logic       read_write_strobe_i,
  output logic            read_write_strobe_o,
  output logic            read_write_strobe_oe_o,
  output logic            link_active_o,
  output logic            refresh_busy_o
);

  localparam int RI_W = $clog2(`REFRESH_INTERVAL_CYC + 1);

  function automatic logic [4:0] lat_cycles(
    input logic [3:0] code,
    input logic       extra
  );
    logic [4:0] base;
    base = (code == 4'h0) ? 5'h01 : {1'b0, code};
    lat_cycles = extra ? {base[3:0], 1'b0} : base;
  endfunction

  function automatic logic [ADDR_W-1:0] burst_mask(input logic [1:0] code);
    logic [5:0] m;
    unique case (code)
      2'h0: m = 6'h3F;
      2'h1: m = 6'h1F;
      2'h2: m = 6'h07;
      2'h3: m = 6'h0F;
    endcase
    burst_mask = {{(ADDR_W-6){1'b0}}, m};
  endfunction

  function automatic logic [ADDR_W-1:0] make_addr(
    input logic [28:0] upper,
    input logic [2:0]  lower
  );
    logic [31:0] full;
    full = {upper, lower};
    make_addr = full[ADDR_W-1:0];
  endfunction

  function automatic logic [ADDR_W-1:0] next_addr(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] mask,
    input logic              wrap
  );
    logic [ADDR_W-1:0] inc;
    inc = addr + ADDR_W'(1);
    next_addr = wrap ? ((addr & ~mask) | (inc & mask)) : inc;
  endfunction

  // System domain: refresh scheduler and latency flag

  logic            cs_n_sys;
  logic            link_active_reg;
  logic [RI_W-1:0] refresh_cnt_reg;
  logic [RI_W-1:0] busy_cnt_reg;
  logic            refresh_busy_reg;
  logic            extra_lat_reg;

  sync2 #(
    .RESET_VAL (1'b1)
  ) u_cs_sync (
    .clk_i   (clk_sys_i),
    .reset_i (reset_i),
    .d_i     (chip_select_n_i),
    .q_o     (cs_n_sys)
  );

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      refresh_cnt_reg <= '0;
    end else if (refresh_cnt_reg == RI_W'(`REFRESH_INTERVAL_CYC - 1)) begin
      refresh_cnt_reg <= '0;
    end else begin
      refresh_cnt_reg <= refresh_cnt_reg + RI_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      busy_cnt_reg     <= '0;
      refresh_busy_reg <= 1'b0;
    end else if (refresh_cnt_reg == '0) begin
      busy_cnt_reg     <= RI_W'(`REFRESH_BUSY_CYC - 1);
      refresh_busy_reg <= 1'b1;
    end else if (busy_cnt_reg != '0) begin
      busy_cnt_reg <= busy_cnt_reg - RI_W'(1);
    end else begin
      refresh_busy_reg <= 1'b0;
    end
  end

  // Frozen while a frame runs, so pin and latency decision agree
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      extra_lat_reg <= 1'b0;
    end else if (cs_n_sys) begin
      extra_lat_reg <= refresh_busy_reg;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      link_active_reg <= 1'b0;
    end else begin
      link_active_reg <= !cs_n_sys;
    end
  end

  assign link_active_o  = link_active_reg;
  assign refresh_busy_o = refresh_busy_reg;

  // Link domain

  logic                   frame_rst;
  logic                   link_clk_n;
  logic                   extra_link;
  psram_pkg::link_state_t state_reg;
  logic [1:0]             cyc_reg;
  logic [31:0]            ca_reg;
  logic [7:0]             pos_byte_reg;
  logic [7:0]             neg_byte_reg;
  logic                   mask_a_reg;
  logic [4:0]             lat_cnt_reg;
  logic                   is_read_reg;
  logic                   is_reg_reg;
  logic [1:0]             reg_sel_reg;
  logic [ADDR_W-1:0]      addr_reg;
  logic [5:0]             beat_reg;
  logic                   wrap_reg;
  logic [15:0]            out_word_reg;
  logic                   pause_reg;
  logic                   pause_due_reg;
  logic [15:0]            cfg0_reg;
  logic [15:0]            cfg1_reg;
  logic [15:0]            reg_rdata;
  logic [15:0]            mem_rdata;
  psram_pkg::mem_wr_t     mem_wr;
  psram_pkg::ca_cmd_t     ca_full;
  logic                   decode_now;
  logic                   lat_done;
  logic                   load_word;
  logic [ADDR_W-1:0]      bmask;
  logic                   hybrid;

  // Chip select high ends every frame state; it only falls while the
  // clock idles low, so release never races a link edge
  assign frame_rst  = reset_i | chip_select_n_i;
  assign link_clk_n = ~link_clk_i;

  sync2 #(
    .RESET_VAL (1'b0)
  ) u_lat_sync (
    .clk_i   (link_clk_i),
    .reset_i (frame_rst),
    .d_i     (extra_lat_reg),
    .q_o     (extra_link)
  );

  always_ff @(posedge link_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      pos_byte_reg <= 8'h00;
      mask_a_reg   <= 1'b1;
    end else begin
      pos_byte_reg <= dq_i;
      mask_a_reg   <= read_write_strobe_i;
    end
  end

  always_ff @(negedge link_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      neg_byte_reg <= 8'h00;
    end else begin
      neg_byte_reg <= dq_i;
    end
  end

  assign ca_full    = {ca_reg, pos_byte_reg, neg_byte_reg};
  assign decode_now = (state_reg == psram_pkg::ST_CA)
                      && (cyc_reg == 2'h3);
  assign lat_done   = (state_reg == psram_pkg::ST_LAT)
                      && (lat_cnt_reg == 5'h00);
  assign load_word  = (lat_done && is_read_reg)
                      || ((state_reg == psram_pkg::ST_RD) && !pause_due_reg);
  assign bmask      = burst_mask(cfg0_reg[`CR0_BL_MSB:`CR0_BL_LSB]);
  assign hybrid     = cfg0_reg[`CR0_HYB_BIT];

  always_ff @(posedge link_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      state_reg   <= psram_pkg::ST_CA;
      cyc_reg     <= 2'h0;
      ca_reg      <= 32'h0000_0000;
      lat_cnt_reg <= 5'h00;
      is_read_reg <= 1'b0;
      is_reg_reg  <= 1'b0;
      reg_sel_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        psram_pkg::ST_CA: begin
          cyc_reg <= cyc_reg + 2'h1;
          if ((cyc_reg != 2'h0) && !decode_now) begin
            ca_reg <= {ca_reg[15:0], pos_byte_reg, neg_byte_reg};
          end
          if (decode_now) begin
            is_read_reg <= ca_full.is_read;
            is_reg_reg  <= ca_full.is_reg;
            reg_sel_reg <= {ca_full.row_col[8], ca_full.col_low[0]};
            lat_cnt_reg <= lat_cycles(cfg0_reg[`CR0_LAT_MSB:`CR0_LAT_LSB],
                                      extra_link) - 5'h01;
            if (!ca_full.is_read && ca_full.is_reg) begin
              state_reg <= psram_pkg::ST_REG_WR;
            end else begin
              state_reg <= psram_pkg::ST_LAT;
            end
          end
        end
        psram_pkg::ST_LAT: begin
          if (lat_cnt_reg == 5'h00) begin
            state_reg <= is_read_reg ? psram_pkg::ST_RD : psram_pkg::ST_WR;
          end else begin
            lat_cnt_reg <= lat_cnt_reg - 5'h01;
          end
        end
        psram_pkg::ST_REG_WR: begin
          // Register loads take exactly one word
          state_reg <= psram_pkg::ST_DONE;
        end
        psram_pkg::ST_RD,
        psram_pkg::ST_WR,
        psram_pkg::ST_DONE: begin
          // Bursts run until chip select rises
          state_reg <= state_reg;
        end
        default: begin
          state_reg <= psram_pkg::ST_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      addr_reg <= '0;
      beat_reg <= 6'h00;
      wrap_reg <= 1'b0;
    end else if ((state_reg == psram_pkg::ST_CA) && (cyc_reg == 2'h2)) begin
      // Row and upper column known after the second word
      addr_reg <= make_addr({ca_reg[12:0], pos_byte_reg, neg_byte_reg},
                            3'h0);
    end else if (decode_now) begin
      addr_reg <= make_addr(ca_full.row_col, ca_full.col_low);
      wrap_reg <= !ca_full.linear;
      beat_reg <= 6'h00;
    end else if (load_word || (state_reg == psram_pkg::ST_WR)) begin
      beat_reg <= beat_reg + 6'h01;
      if (wrap_reg && hybrid && (beat_reg == bmask[5:0])) begin
        wrap_reg <= 1'b0;
        addr_reg <= (addr_reg | bmask) + ADDR_W'(1);
      end else begin
        // Linear runs roll over at the array end
        addr_reg <= next_addr(addr_reg, bmask, wrap_reg);
      end
    end
  end

  // Read words come from flops; a row crossing during a refresh
  // collision costs one strobe-low cycle
  always_ff @(posedge link_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      out_word_reg  <= 16'h0000;
      pause_reg     <= 1'b0;
      pause_due_reg <= 1'b0;
    end else if (load_word) begin
      out_word_reg  <= is_reg_reg ? reg_rdata : mem_rdata;
      pause_reg     <= 1'b0;
      pause_due_reg <= extra_link && !is_reg_reg && !wrap_reg
                       && (addr_reg[`ROW_W-1:0] == {`ROW_W{1'b1}});
    end else if (state_reg == psram_pkg::ST_RD) begin
      pause_reg     <= 1'b1;
      pause_due_reg <= 1'b0;
    end
  end

  always_comb begin
    unique case (reg_sel_reg)
      `REG_SEL_ID0: reg_rdata = ID0_VALUE;
      `REG_SEL_ID1: reg_rdata = ID1_VALUE;
      `REG_SEL_CR0: reg_rdata = cfg0_reg;
      `REG_SEL_CR1: reg_rdata = cfg1_reg;
    endcase
  end

  // Second byte completes the word, so the load lands on the falling
  // edge and survives a frame that stops right after it
  always_ff @(negedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg0_reg <= `CR0_RESET;
      cfg1_reg <= `CR1_RESET;
    end else if (state_reg == psram_pkg::ST_REG_WR) begin
      if (reg_sel_reg == `REG_SEL_CR0) begin
        cfg0_reg <= {pos_byte_reg, dq_i};
      end
      if (reg_sel_reg == `REG_SEL_CR1) begin
        cfg1_reg <= {pos_byte_reg, dq_i};
      end
    end
  end

  assign mem_wr.we   = (state_reg == psram_pkg::ST_WR);
  assign mem_wr.be   = {!mask_a_reg, !read_write_strobe_i};
  assign mem_wr.data = {pos_byte_reg, dq_i};

  // Array runs on the falling edge: writes finish with the frame and
  // reads are ready half a cycle before the word is presented
  word_memory #(
    .ADDR_W (ADDR_W)
  ) u_array (
    .clk_i   (link_clk_n),
    .addr_i  (addr_reg),
    .wr_i    (mem_wr),
    .rdata_o (mem_rdata)
  );

  always_comb begin
    read_write_strobe_oe_o = 1'b0;
    read_write_strobe_o    = 1'b0;
    unique case (state_reg)
      psram_pkg::ST_CA: begin
        read_write_strobe_oe_o = !chip_select_n_i;
        read_write_strobe_o    = extra_lat_reg;
      end
      psram_pkg::ST_LAT: begin
        // Writes hand the strobe to the master here
        read_write_strobe_oe_o = is_read_reg;
      end
      psram_pkg::ST_RD: begin
        read_write_strobe_oe_o = 1'b1;
        read_write_strobe_o    = link_clk_i && !pause_reg;
      end
      psram_pkg::ST_WR,
      psram_pkg::ST_REG_WR,
      psram_pkg::ST_DONE: begin
        read_write_strobe_oe_o = 1'b0;
      end
      default: begin
        read_write_strobe_oe_o = 1'b0;
      end
    endcase
  end

  assign dq_oe_o = (state_reg == psram_pkg::ST_RD);
  // Byte A in the high phase, byte B in the low phase
  assign dq_o    = link_clk_i ? out_word_reg[15:8]
                              : out_word_reg[7:0];

endmodule

`default_nettype wire

/* testbench/psram_link_properties.sv */
// Purpose: port checks on the octal memory transaction block
// Assumes: link clock is low whenever chip select changes
// Notes:   frame helpers clear asynchronously while chip select is high
`timescale 1ns/1ps
`default_nettype none
module psram_link_properties (
  input wire logic       clk_sys_i,
  input wire logic       reset_i,
  input wire logic       link_clk_i,
  input wire logic       chip_select_n_i,
  input wire logic [7:0] dq_i,
  input wire logic [7:0] dq_o,
  input wire logic       dq_oe_o,
  input wire logic       read_write_strobe_i,
  input wire logic       read_write_strobe_o,
  input wire logic       read_write_strobe_oe_o,
  input wire logic       link_active_o,
  input wire logic       refresh_busy_o
);
  logic [3:0] edge_cnt_reg;
  logic       is_read_reg;
  // Rising edges seen in this frame; saturates so long bursts stay quiet
  always_ff @(posedge link_clk_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      edge_cnt_reg <= 4'h0;
    end else if (edge_cnt_reg != 4'hF) begin
      edge_cnt_reg <= edge_cnt_reg + 4'h1;
    end
  end
  always_ff @(posedge link_clk_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      is_read_reg <= 1'b0;
    end else if (edge_cnt_reg == 4'h0) begin
      is_read_reg <= dq_i[7];
    end
  end
  a_ca_strobe_out: assert property (
    @(posedge link_clk_i) disable iff (reset_i || chip_select_n_i)
    edge_cnt_reg < 4'h3 |-> read_write_strobe_oe_o)
    else $error("strobe not driven during command words");
  a_ca_flag_steady: assert property (
    @(posedge link_clk_i) disable iff (reset_i || chip_select_n_i)
    edge_cnt_reg inside {4'h1, 4'h2} |-> $stable(read_write_strobe_o))
    else $error("latency flag changed within command words");
  a_wr_strobe_free: assert property (
    @(posedge link_clk_i) disable iff (reset_i || chip_select_n_i)
    !is_read_reg && edge_cnt_reg >= 4'h4 |-> !read_write_strobe_oe_o)
    else $error("device drives strobe after command words of a write");
  a_wr_dq_quiet: assert property (
    @(posedge link_clk_i) disable iff (reset_i || chip_select_n_i)
    !is_read_reg && edge_cnt_reg != 4'h0 |-> !dq_oe_o)
    else $error("device drives data during a write");
  a_rd_no_early: assert property (
    @(posedge link_clk_i) disable iff (reset_i || chip_select_n_i)
    edge_cnt_reg <= 4'h4 |-> !dq_oe_o)
    else $error("read data before the initial latency");
  a_rd_strobe_own: assert property (
    @(posedge link_clk_i) disable iff (reset_i || chip_select_n_i)
    is_read_reg && edge_cnt_reg != 4'h0 |-> read_write_strobe_oe_o)
    else $error("strobe released during a read");
  a_rd_strobe_low: assert property (
    @(posedge link_clk_i) disable iff (reset_i || chip_select_n_i)
    dq_oe_o |-> !read_write_strobe_o && read_write_strobe_oe_o)
    else $error("read strobe not low at end of low phase");
  a_idle_released: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    chip_select_n_i [*3] |-> !dq_oe_o && !read_write_strobe_oe_o)
    else $error("lines driven while deselected");
  a_active_follow: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    chip_select_n_i ##1 !chip_select_n_i |-> ##[1:4] link_active_o)
    else $error("frame activity not seen in system domain");
  a_busy_window: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    $rose(refresh_busy_o) |-> refresh_busy_o [*5] ##1 !refresh_busy_o)
    else $error("refresh window length wrong");
endmodule
bind ddr_octal_psram_transactions psram_link_properties u_link_props (
  .clk_sys_i(clk_sys_i),
  .reset_i(reset_i),
  .link_clk_i(link_clk_i),
  .chip_select_n_i(chip_select_n_i),
  .dq_i(dq_i),
  .dq_o(dq_o),
  .dq_oe_o(dq_oe_o),
  .read_write_strobe_i(read_write_strobe_i),
  .read_write_strobe_o(read_write_strobe_o),
  .read_write_strobe_oe_o(read_write_strobe_oe_o),
  .link_active_o(link_active_o),
  .refresh_busy_o(refresh_busy_o)
);
`default_nettype wire

/* testbench/psram_bus_master.sv */
// Purpose: behavioural bus master for the octal memory link
// Assumes: 30 ns link period, clock stands low between frames
// Notes:   data set mid-phase so it is centred on each link edge
`timescale 1ns/1ps
`default_nettype none
module psram_bus_master (
  output logic            link_clk_o,
  output logic            chip_select_n_o,
  output logic      [7:0] dq_o,
  output logic            strobe_o,
  input  wire logic [7:0] dq_i,
  input  wire logic       strobe_i
);
  int          lat = 6;
  logic [15:0] words [16];
  logic [1:0]  masks [16];
  initial begin
    // Driven after time zero so the frame reset sees a rising edge
    #1;
    link_clk_o      = 1'b0;
    chip_select_n_o = 1'b1;
    dq_o            = 8'h00;
    strobe_o        = 1'b0;
  end
  // Unowned lines flip so a stale value never looks valid
  task automatic phase(input logic [7:0] d, input logic s, input logic own);
    dq_o     = d;
    strobe_o = own ? s : ~strobe_o;
    #7.5;
    link_clk_o = ~link_clk_o;
    #7.5;
  endtask
  task automatic frame(input logic [47:0] ca, input int n, input logic wr,
                       input logic zl);
    int         t;
    int         got;
    logic       lat2;
    logic       hit;
    logic [7:0] hi;
    chip_select_n_o = 1'b0;
    #45;
    for (int k = 0; k < 6; k++) begin
      phase(ca[47-8*k -: 8], 1'b0, 1'b0);
      if (k == 0) begin
        lat2 = strobe_i;
      end
    end
    t = zl ? 0 : (lat2 ? 2 * lat : lat);
    for (int k = 0; k < 2 * t; k++) begin
      phase(~dq_o, 1'b0, wr);
    end
    got = 0;
    for (int k = 0; k < n + 4 && got < n; k++) begin
      if (wr) begin
        phase(words[got][15:8], masks[got][1], !zl);
        phase(words[got][7:0], masks[got][0], !zl);
        got++;
      end else begin
        phase(~dq_o, 1'b0, 1'b0);
        hit = strobe_i;
        hi  = dq_i;
        phase(~dq_o, 1'b0, 1'b0);
        if (hit) begin // Low strobe in the high phase is a pause
          words[got] = {hi, dq_i};
          got++;
        end
      end
    end
    #15;
    chip_select_n_o = 1'b1;
    #60;
  endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Purpose: self-checking bench for the octal memory transaction block
// Assumes: the master model owns all link pins that the device is not driving
// Notes:   array shrunk to 10 address bits to reach its end quickly
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Identification values are arbitrary
  localparam logic [15:0] ID0_VAL = 16'h5A3C;
  localparam logic [15:0] ID1_VAL = 16'h00B7;
  logic            clk_sys_i = 1'b0;
  logic            reset_i   = 1'b0;
  wire logic       link_clk;
  wire logic       cs_n;
  wire logic [7:0] m_dq;
  wire logic       m_str;
  logic      [7:0] d_dq;
  logic            d_dq_oe;
  logic            d_str;
  logic            d_str_oe;
  wire logic [7:0] dq_bus  = d_dq_oe ? d_dq : m_dq;
  wire logic       str_bus = d_str_oe ? d_str : m_str;
  int              failures = 0;
  int              checked  = 0;
  psram_bus_master u_master (.link_clk_o(link_clk), .chip_select_n_o(cs_n),
    .dq_o(m_dq), .strobe_o(m_str), .dq_i(dq_bus), .strobe_i(str_bus));
  ddr_octal_psram_transactions #(.ADDR_W(10), .ID0_VALUE(ID0_VAL),
    .ID1_VALUE(ID1_VAL)) u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .link_clk_i(link_clk), .chip_select_n_i(cs_n), .dq_i(dq_bus),
    .dq_o(d_dq), .dq_oe_o(d_dq_oe), .read_write_strobe_i(str_bus),
    .read_write_strobe_o(d_str), .read_write_strobe_oe_o(d_str_oe),
    .link_active_o(), .refresh_busy_o());
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [47:0] ca(input logic rd, input logic lin,
                                     input logic [9:0] a);
    ca = {rd, 1'b0, lin, 22'h0, a[9:3], 13'h0, a[2:0]};
  endfunction
  function automatic logic [47:0] rca(input logic rd, input logic [1:0] s);
    rca = {rd, 2'b11, 20'h0, s[1], 23'h0, s[0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic put(input int i, input logic [15:0] w, input logic [1:0] m);
    u_master.words[i] = w;
    u_master.masks[i] = m;
  endtask
  task automatic rd(input logic [47:0] c, input int n);
    for (int i = 0; i < 16; i++) begin
      u_master.words[i] = 'x;
    end
    u_master.frame(c, n, 1'b0, 1'b0);
  endtask
  task automatic t_registers();
    put(0, 16'h8012, 2'b00);
    u_master.frame(rca(1'b0, 2'b10), 1, 1'b1, 1'b1);
    u_master.lat = 1;
    rd(rca(1'b1, 2'b10), 1);
    check(u_master.words[0], 16'h8012);
    put(0, 16'h0000, 2'b00);
    u_master.frame(rca(1'b0, 2'b00), 1, 1'b1, 1'b1);
    rd(rca(1'b1, 2'b00), 1);
    check(u_master.words[0], ID0_VAL);
    rd(rca(1'b1, 2'b01), 1);
    check(u_master.words[0], ID1_VAL);
    put(0, 16'hC3A5, 2'b00);
    u_master.frame(rca(1'b0, 2'b11), 1, 1'b1, 1'b1);
    rd(rca(1'b1, 2'b11), 1);
    check(u_master.words[0], 16'hC3A5);
  endtask
  task automatic t_masked();
    put(0, 16'h1234, 2'b00);
    put(1, 16'h5678, 2'b00);
    u_master.frame(ca(1'b0, 1'b1, 10'h008), 2, 1'b1, 1'b0);
    put(0, 16'hAAAA, 2'b10);
    put(1, 16'hBBBB, 2'b01);
    u_master.frame(ca(1'b0, 1'b1, 10'h008), 2, 1'b1, 1'b0);
    rd(ca(1'b1, 1'b1, 10'h008), 2);
    check(u_master.words[0], 16'h12AA);
    check(u_master.words[1], 16'hBB78);
  endtask
  task automatic t_wrap();
    for (int i = 0; i < 8; i++) begin
      put(i, {8'h01, 8'(i)}, 2'b00);
    end
    u_master.frame(ca(1'b0, 1'b1, 10'h010), 8, 1'b1, 1'b0);
    rd(ca(1'b1, 1'b0, 10'h016), 4);
    for (int i = 0; i < 4; i++) begin
      check(u_master.words[i], {8'h01, 8'((6 + i) % 8)});
    end
    for (int i = 0; i < 4; i++) begin
      put(i, {8'hE0, 8'(i)}, 2'b00);
    end
    u_master.frame(ca(1'b0, 1'b0, 10'h016), 4, 1'b1, 1'b0);
    rd(ca(1'b1, 1'b1, 10'h010), 2);
    check(u_master.words[0], 16'hE002);
    check(u_master.words[1], 16'hE003);
    // Hybrid: one wrap over 10..17, then linear from 18
    put(0, 16'h8016, 2'b00);
    u_master.frame(rca(1'b0, 2'b10), 1, 1'b1, 1'b1);
    for (int i = 0; i < 10; i++) begin
      put(i, {8'hB0, 8'(i)}, 2'b00);
    end
    u_master.frame(ca(1'b0, 1'b0, 10'h016), 10, 1'b1, 1'b0);
    rd(ca(1'b1, 1'b1, 10'h018), 2);
    check(u_master.words[0], 16'hB008);
    check(u_master.words[1], 16'hB009);
  endtask
  task automatic t_ends();
    put(0, 16'hC0DE, 2'b00);
    put(1, 16'hF00D, 2'b00);
    u_master.frame(ca(1'b0, 1'b1, 10'h3FF), 2, 1'b1, 1'b0);
    rd(ca(1'b1, 1'b1, 10'h000), 1);
    check(u_master.words[0], 16'hF00D);
    put(0, 16'hD001, 2'b00);
    put(1, 16'hD002, 2'b00);
    u_master.frame(ca(1'b0, 1'b1, 10'h1FF), 2, 1'b1, 1'b0);
    rd(ca(1'b1, 1'b1, 10'h1FF), 2);
    check(u_master.words[0], 16'hD001);
    check(u_master.words[1], 16'hD002);
  endtask
  task automatic report_and_stop();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    // Raised after time zero so every asynchronous reset sees an edge
    #1;
    reset_i = 1'b1;
    repeat (20) @(negedge clk_sys_i);
    reset_i = 1'b0;
    repeat (5) @(negedge clk_sys_i);
    t_registers();
    t_masked();
    t_wrap();
    t_ends();
    report_and_stop();
  end
  // All frames together take about 7 us
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
